// ---- rtl/adc_sample_packetizer.v ----
// Converter control: register file, trigger sequencing, sample formatting and packet output
`timescale 1ns/1ps
`include "adc_map.vh"
module adc_sample_packetizer (
    input  wire        mclk,
    input  wire        rst,
    // Peripheral register port, whole words only
    input  wire        reg_sel,
    input  wire        reg_wr,
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    output reg  [31:0] reg_rdata,
    output reg         reg_ack,
    // Trigger pin, asynchronous to mclk
    input  wire        trig_pin,
    // Converter analogue front end
    output reg         conv_start,
    output reg  [1:0]  conv_pin,
    output reg         conv_cal,
    input  wire        conv_done,
    input  wire [11:0] conv_result,
    // Byte stream toward the channel-end network
    output wire        net_valid,
    input  wire        net_ready,
    output reg  [7:0]  net_byte,
    output reg  [23:0] net_dest,
    output reg         net_last
);
    ////////////////////////////////////////////////////////////////////////
    reg  [31:0] pin_r [0:`ADC_NPINS-1];
    reg         en_r;
    reg         cal_r;
    reg  [1:0]  wid_r;
    reg  [7:0]  spp_r;
    reg         drop_r;
    reg  [2:0]  calcnt_r;
    reg  [1:0]  next_pin_r;
    reg  [1:0]  cur_pin_r;
    reg         busy_r;
    reg         trig_s1_r;
    reg         trig_s2_r;
    reg         trig_d_r;
    reg  [31:0] sh_r;
    reg  [2:0]  bytes_r;
    reg         sh_act_r;
    reg  [23:0] sh_dest_r;
    reg         sh_last_r;
    reg  [7:0]  pkt_cnt_r;
    reg         close_req_r;
    reg         out_v_r;
    reg  [2:0]  bytes_nxt;
    reg  [31:0] fmt_nxt;
    reg  [1:0]  pick_nxt;
    reg         found_nxt;
    integer     i;
    integer     k;

    wire        trig_rise;
    wire        wr_hit;
    wire        rd_gen;
    wire        buf_in_ready;
    wire        buf_out_valid;
    wire        buf_out_ready;
    wire [63:0] buf_in_data;
    wire [63:0] buf_out_data;
    wire        sample_ok;
    wire        pkt_end;
    wire [7:0]  pkt_cnt_inc;
    wire        close_hit;

    function [2:0] width_bytes;
        input [1:0] w;
        begin
            case (w)
                `WID_8:  width_bytes = 3'h1;
                `WID_16: width_bytes = 3'h2;
                `WID_32: width_bytes = 3'h4;
                // Reserved code falls back to two bytes rather than stalling
                default: width_bytes = 3'h2;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Trigger synchroniser; edge detect only on the second stage
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
            trig_d_r  <= 1'b0;
        end else begin
            trig_s1_r <= trig_pin;
            trig_s2_r <= trig_s1_r;
            trig_d_r  <= trig_s2_r;
        end
    end
    assign trig_rise = trig_s2_r && !trig_d_r;

    ////////////////////////////////////////////////////////////////////////
    // Register access
    assign wr_hit = reg_sel && reg_wr;
    assign rd_gen = reg_sel && !reg_wr && (reg_addr == `ADC_GEN_OFS);

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (i = 0; i < `ADC_NPINS; i = i + 1)
                pin_r[i] <= `PIN_RESET;
            en_r      <= 1'b0;
            cal_r     <= 1'b0;
            wid_r     <= `GEN_WID_RESET;
            spp_r     <= `GEN_SPP_RESET;
            reg_rdata <= 32'h00000000;
            reg_ack   <= 1'b0;
        end else begin
            reg_ack <= reg_sel;
            if (wr_hit) begin
                // Pin words frozen while converting, so routing cannot change mid-stream
                if (!en_r && reg_addr[7:4] == 4'h0 && reg_addr[1:0] == 2'h0)
                    pin_r[reg_addr[3:2]] <= {reg_wdata[`PIN_DEST_HI:`PIN_DEST_LO],
                                             7'h00, reg_wdata[`PIN_EN_BIT]};
                if (reg_addr == `ADC_GEN_OFS) begin
                    en_r  <= reg_wdata[`GEN_EN_BIT];
                    cal_r <= reg_wdata[`GEN_CAL_BIT];
                    wid_r <= reg_wdata[`GEN_WID_HI:`GEN_WID_LO];
                    spp_r <= reg_wdata[`GEN_SPP_HI:`GEN_SPP_LO];
                end
            end
            if (reg_sel && !reg_wr) begin
                // Drop flag shown before the read clear lands
                case (reg_addr)
                    `ADC_PIN0_OFS: reg_rdata <= pin_r[0];
                    `ADC_PIN1_OFS: reg_rdata <= pin_r[1];
                    `ADC_PIN2_OFS: reg_rdata <= pin_r[2];
                    `ADC_PIN3_OFS: reg_rdata <= pin_r[3];
                    `ADC_GEN_OFS:  reg_rdata <= {7'h00, drop_r, 6'h00, wid_r, spp_r,
                                                 6'h00, cal_r, en_r};
                    default:       reg_rdata <= 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next enabled pin after the last one sampled, round robin
    always @* begin
        pick_nxt  = next_pin_r;
        found_nxt = 1'b0;
        // Counting down lets the nearest enabled pin at or after the pointer win
        for (k = `ADC_NPINS - 1; k >= 0; k = k - 1)
            if (pin_r[(next_pin_r + k[1:0]) & 2'h3][`PIN_EN_BIT]) begin
                pick_nxt  = next_pin_r + k[1:0];
                found_nxt = 1'b1;
            end
    end

    // Calibration pulses still convert but never reach the stream
    assign sample_ok = (calcnt_r == `CAL_PULSES);

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            calcnt_r   <= 3'h0;
            next_pin_r <= 2'h0;
            cur_pin_r  <= 2'h0;
            busy_r     <= 1'b0;
            conv_start <= 1'b0;
            conv_pin   <= 2'h0;
            conv_cal   <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            conv_cal   <= cal_r;
            if (!en_r) begin
                calcnt_r <= 3'h0;
                busy_r   <= 1'b0;
            end else begin
                if (trig_rise && found_nxt && !busy_r) begin
                    conv_start <= 1'b1;
                    conv_pin   <= pick_nxt;
                    cur_pin_r  <= pick_nxt;
                    next_pin_r <= pick_nxt + 2'h1;
                    busy_r     <= 1'b1;
                end
                if (busy_r && conv_done) begin
                    busy_r <= 1'b0;
                    if (!sample_ok)
                        calcnt_r <= calcnt_r + 3'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Left aligned formatting
    always @* begin
        bytes_nxt = width_bytes(wid_r);
        case (wid_r)
            `WID_8:  fmt_nxt = {conv_result[11:4], 24'h000000};
            `WID_32: fmt_nxt = {conv_result, 20'h00000};
            default: fmt_nxt = {conv_result, 4'h0, 16'h0000};
        endcase
    end

    assign pkt_cnt_inc = pkt_cnt_r + 8'h01;
    assign pkt_end     = (spp_r != 8'h00) && (pkt_cnt_inc == spp_r);
    assign buf_in_data = {pin_r[cur_pin_r][`PIN_DEST_HI:`PIN_DEST_LO],
                          pkt_end, bytes_nxt, 4'h0, fmt_nxt};

    // Two entries ride out a short stall; a third waiting sample is dropped
    word_buf2 #(.W(64)) u_buf (
        .mclk      (mclk),
        .rst       (rst),
        .in_valid  (busy_r && conv_done && sample_ok),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in_data),
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready),
        .out_data  (buf_out_data)
    );

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            drop_r    <= `GEN_DROP_RESET;
            pkt_cnt_r <= 8'h00;
        end else begin
            // A new drop beats the read clear
            if (busy_r && conv_done && sample_ok && !buf_in_ready)
                drop_r <= 1'b1;
            else if (rd_gen)
                drop_r <= 1'b0;
            if (busy_r && conv_done && sample_ok && buf_in_ready)
                pkt_cnt_r <= pkt_end ? 8'h00 : pkt_cnt_inc;
            if (!en_r || close_hit)
                pkt_cnt_r <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serialiser, most significant byte first
    assign buf_out_ready = !sh_act_r;
    assign net_valid     = out_v_r;
    // Only a running converter has an open packet to close
    assign close_hit     = reg_sel && en_r && (spp_r == 8'h00);

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            sh_r        <= 32'h00000000;
            bytes_r     <= 3'h0;
            sh_act_r    <= 1'b0;
            sh_dest_r   <= 24'h000000;
            sh_last_r   <= 1'b0;
            close_req_r <= 1'b0;
            out_v_r     <= 1'b0;
            net_byte    <= 8'h00;
            net_dest    <= 24'h000000;
            net_last    <= 1'b0;
        end else begin
            if (close_hit)
                close_req_r <= 1'b1;
            if (buf_out_valid && !sh_act_r) begin
                sh_r      <= buf_out_data[31:0];
                bytes_r   <= buf_out_data[38:36];
                sh_last_r <= buf_out_data[39];
                sh_dest_r <= buf_out_data[63:40];
                sh_act_r  <= 1'b1;
            end
            if (out_v_r && net_ready)
                out_v_r <= 1'b0;
            if (sh_act_r && (!out_v_r || net_ready)) begin
                out_v_r  <= 1'b1;
                net_byte <= sh_r[31:24];
                net_dest <= sh_dest_r;
                sh_r     <= {sh_r[23:0], 8'h00};
                bytes_r  <= bytes_r - 3'h1;
                net_last <= (bytes_r == 3'h1) && (sh_last_r || close_req_r);
                if (bytes_r == 3'h1) begin
                    sh_act_r <= 1'b0;
                    if (close_req_r && !close_hit)
                        close_req_r <= 1'b0;
                end
            end
        end
    end
endmodule // adc_sample_packetizer

// ---- rtl/adc_map.vh ----
// Register offsets, field positions, reset values and timing counts of the sample packetizer
`ifndef ADC_MAP_VH
`define ADC_MAP_VH
`define ADC_PIN0_OFS        8'h00
`define ADC_PIN1_OFS        8'h04
`define ADC_PIN2_OFS        8'h08
`define ADC_PIN3_OFS        8'h0c
`define ADC_GEN_OFS         8'h20
`define ADC_NPINS           4
`define PIN_DEST_HI         31
`define PIN_DEST_LO         8
`define PIN_EN_BIT          0
`define GEN_DROP_BIT        24
`define GEN_WID_HI          17
`define GEN_WID_LO          16
`define GEN_SPP_HI          15
`define GEN_SPP_LO          8
`define GEN_CAL_BIT         1
`define GEN_EN_BIT          0
`define WID_8               2'h0
`define WID_16              2'h1
`define WID_RSVD            2'h2
`define WID_32              2'h3
`define PIN_RESET           32'h00000000
`define GEN_WID_RESET       2'h1
`define GEN_SPP_RESET       8'h01
`define GEN_DROP_RESET      1'b1
`define CAL_PULSES          3'h6
`define BUF_DEPTH           2
`endif

// ---- rtl/word_buf2.v ----
// Two-entry valid/ready buffer, each entry holding one formatted sample with its routing
`timescale 1ns/1ps
module word_buf2 #(
    parameter W = 64
) (
    input  wire         mclk,
    input  wire         rst,
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    reg  [W-1:0] mem_r [0:1];
    reg          wr_r;
    reg          rd_r;
    reg  [1:0]   cnt_r;
    wire         push;
    wire         pop;

    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = mem_r[rd_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_r     <= 1'b0;
            rd_r     <= 1'b0;
            cnt_r    <= 2'h0;
            mem_r[0] <= {W{1'b0}};
            mem_r[1] <= {W{1'b0}};
        end else begin
            if (push) begin
                mem_r[wr_r] <= in_data;
                wr_r        <= ~wr_r;
            end
            if (pop)
                rd_r <= ~rd_r;
            if (push && !pop)
                cnt_r <= cnt_r + 2'h1;
            else if (pop && !push)
                cnt_r <= cnt_r - 2'h1;
        end
    end
endmodule // word_buf2

// ---- verification/adc_sample_packetizer_asserts.sv ----
// Port-level checks on the sample packetizer
`timescale 1ns/1ps
module adc_sample_packetizer_asserts (
    input wire        mclk,
    input wire        rst,
    input wire        reg_sel,
    input wire        reg_wr,
    input wire [7:0]  reg_addr,
    input wire [31:0] reg_wdata,
    input wire [31:0] reg_rdata,
    input wire        reg_ack,
    input wire        conv_start,
    input wire [1:0]  conv_pin,
    input wire        net_valid,
    input wire        net_ready,
    input wire [7:0]  net_byte,
    input wire [23:0] net_dest,
    input wire        net_last
);
    // Shadow of the enables, so starts can be tied to what software set
    reg       en_r;
    reg [3:0] pen_r;
    wire      wr_gen = reg_sel && reg_wr && reg_addr == 8'h20;
    wire      pin_hit = reg_addr[7:4] == 4'h0 && reg_addr[1:0] == 2'h0;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            en_r  <= 1'b0;
            pen_r <= 4'h0;
        end else begin
            if (wr_gen)
                en_r <= reg_wdata[0];
            if (reg_sel && reg_wr && !en_r && pin_hit)
                pen_r[reg_addr[3:2]] <= reg_wdata[0];
        end
    end
    ////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence rd_gen;
        reg_sel && !reg_wr && reg_addr == 8'h20;
    endsequence
    sequence rd_pin;
        reg_sel && !reg_wr && pin_hit;
    endsequence
    sequence held;
        net_valid && !net_ready;
    endsequence
    chk_ack_after_sel: assert property (reg_sel |=> reg_ack)
        else $error("ack missing");
    chk_ack_only_sel: assert property (!reg_sel |=> !reg_ack)
        else $error("stray ack");
    chk_gen_reserved: assert property (rd_gen |=> reg_rdata[31:25] == 7'h00
        && reg_rdata[23:18] == 6'h00 && reg_rdata[7:2] == 6'h00) else $error("gen reserved");
    chk_pin_reserved: assert property (rd_pin |=> reg_rdata[7:1] == 7'h00)
        else $error("pin reserved");
    chk_unmapped_zero: assert property (reg_sel && !reg_wr && reg_addr == 8'h10
        |=> reg_rdata == 32'h0) else $error("unmapped read");
    chk_byte_held: assert property (held |=> net_valid && $stable(net_byte)
        && $stable(net_dest) && $stable(net_last)) else $error("byte not held");
    chk_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("start too long");
    chk_start_enabled: assert property (conv_start |-> en_r || $past(en_r))
        else $error("start while off");
    chk_start_pin: assert property (conv_start |-> pen_r[conv_pin])
        else $error("disabled pin");
    chk_off_quiet: assert property (wr_gen && !reg_wdata[0] |-> ##2 !conv_start [*8])
        else $error("start after off");
endmodule // adc_sample_packetizer_asserts

// ---- verification/adc_far_model.sv ----
// Converter front end and receiving channel-end stand-in
`timescale 1ns/1ps
module adc_far_model (
    input  wire        mclk,
    input  wire        rst,
    input  wire        conv_start,
    input  wire [1:0]  conv_pin,
    input  wire        conv_cal,
    output reg         conv_done,
    output reg  [11:0] conv_result,
    input  wire        stall,
    input  wire        slow,
    output reg         net_ready
);
    reg [2:0]  busy_r;
    reg [11:0] val_r;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            busy_r      <= 3'h0;
            val_r       <= 12'h000;
            conv_done   <= 1'b0;
            conv_result <= 12'h000;
            net_ready   <= 1'b0;
        end else begin
            conv_done   <= busy_r == 3'h1;
            // Result is garbage outside the done pulse
            conv_result <= (busy_r == 3'h1) ? val_r : ~conv_result;
            if (conv_start) begin
                busy_r <= 3'h4;
                val_r  <= conv_cal ? 12'h3e8 : {1'b1, conv_pin, 9'h0b7};
            end else if (busy_r != 3'h0) begin
                busy_r <= busy_r - 3'h1;
            end
            net_ready <= !stall && !(slow && net_ready);
        end
    end
endmodule // adc_far_model

// ---- verification/test_adc_sample_packetizer.sv ----
// Self-checking bench for the sample packetizer
`timescale 1ns/1ps
module test_adc_sample_packetizer;
    reg         mclk = 1'b0, rst = 1'b1, reg_sel = 1'b0, reg_wr = 1'b0;
    reg  [7:0]  reg_addr = 8'h00;
    reg  [31:0] reg_wdata = 32'h0;
    reg         trig_pin = 1'b0, stall = 1'b0, slow = 1'b0;
    wire [31:0] reg_rdata;
    wire        reg_ack, conv_start, conv_cal, conv_done, net_valid, net_ready, net_last;
    wire [1:0]  conv_pin;
    wire [11:0] conv_result;
    wire [7:0]  net_byte;
    wire [23:0] net_dest;
    integer     bad_count = 0, samples_checked = 0, m;
    reg  [7:0]  qb[$];
    reg  [23:0] qd[$];
    reg         ql[$];
    always #5 mclk = ~mclk;
    adc_sample_packetizer dut_u (.mclk(mclk), .rst(rst), .reg_sel(reg_sel), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
        .trig_pin(trig_pin), .conv_start(conv_start), .conv_pin(conv_pin), .conv_cal(conv_cal),
        .conv_done(conv_done), .conv_result(conv_result), .net_valid(net_valid),
        .net_ready(net_ready), .net_byte(net_byte), .net_dest(net_dest), .net_last(net_last));
    adc_far_model far_u (.mclk(mclk), .rst(rst), .conv_start(conv_start), .conv_pin(conv_pin),
        .conv_cal(conv_cal), .conv_done(conv_done), .conv_result(conv_result), .stall(stall),
        .slow(slow), .net_ready(net_ready));
    always @(posedge mclk) begin
        if (net_valid === 1'b1 && net_ready === 1'b1) begin
            qb.push_back(net_byte);
            qd.push_back(net_dest);
            ql.push_back(net_last);
        end
    end
    ////////////////////////////////////////
    task report_and_stop;
        begin
            $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
            if (bad_count == 0 && samples_checked > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    task cmp(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task acc(input wr, input [7:0] a, input [31:0] d);
        begin
            @(negedge mclk);
            reg_sel = 1'b1;
            reg_wr = wr;
            reg_addr = a;
            reg_wdata = d;
            @(negedge mclk);
            reg_sel = 1'b0;
            cmp(reg_ack, 1);
        end
    endtask
    task rd(input [7:0] a, input [31:0] e);
        begin
            acc(1'b0, a, 32'h0);
            cmp(reg_rdata, e);
        end
    endtask
    task trig(input integer n);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                @(negedge mclk) trig_pin = 1'b1;
                repeat (3) @(negedge mclk);
                trig_pin = 1'b0;
                repeat (12) @(negedge mclk);
            end
        end
    endtask
    task clear;
        begin
            qb.delete();
            qd.delete();
            ql.delete();
        end
    endtask
    task wait_bytes(input integer n);
        integer k;
        begin
            for (k = 0; k < 600 && qb.size() < n; k = k + 1)
                @(negedge mclk);
            if (qb.size() < n) begin
                bad_count = bad_count + 1;
                $display("Error at %0t: byte wait ran out", $time);
                report_and_stop;
            end
        end
    endtask
    // Expected word rebuilt from the pin that the destination names
    task chk_stream(input integer nb, input integer ns, input integer spp, input [11:0] fix);
        integer i, j;
        reg [31:0] w;
        begin
            wait_bytes(nb * ns);
            repeat (30) @(negedge mclk);
            cmp(qb.size(), nb * ns);
            for (i = 0; i < ns; i = i + 1) begin
                cmp(qd[i*nb] == 24'habcdef || qd[i*nb] == 24'h123456, 1);
                w = {(fix != 12'h0) ? fix : (qd[i*nb] == 24'habcdef) ? 12'h8b7 : 12'heb7, 20'h0};
                for (j = 0; j < nb; j = j + 1) begin
                    cmp(qb[i*nb+j], w[31-8*j -: 8]);
                    cmp(qd[i*nb+j], qd[i*nb]);
                    cmp(ql[i*nb+j], j == nb - 1 && spp != 0 && (i + 1) % spp == 0);
                end
            end
        end
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        rd(8'h0c, 32'h0);
        rd(8'h20, 32'h01010100);
        rd(8'h20, 32'h00010100);
        rd(8'h10, 32'h0);
        $display("test reset_values done");
        acc(1, 8'h00, 32'habcdef01);
        acc(1, 8'h0c, 32'h123456ff);
        rd(8'h0c, 32'h12345601);
        acc(1, 8'h20, 32'h00000201);
        acc(1, 8'h00, 32'h0);
        rd(8'h00, 32'habcdef01);
        slow = 1'b1;
        trig(6);
        repeat (20) @(negedge mclk);
        cmp(qb.size(), 0);
        trig(4);
        chk_stream(1, 4, 2, 12'h0);
        cmp(qd[0] != qd[1], 1);
        slow = 1'b0;
        $display("test width8_packets done");
        for (m = 1; m < 4; m = m + 1) begin
            acc(1, 8'h20, 32'h0);
            clear;
            acc(1, 8'h20, {14'h0, m[1:0], 16'h0101});
            trig(6);
            trig(2);
            chk_stream((m == 3) ? 4 : 2, 2, 1, 12'h0);
        end
        $display("test widths done");
        acc(1, 8'h20, 32'h0);
        clear;
        acc(1, 8'h20, 32'h00010103);
        trig(8);
        wait_bytes(4);
        repeat (2) begin
            qb.delete(0);
            qd.delete(0);
            ql.delete(0);
        end
        chk_stream(2, 1, 1, 12'h3e8);
        $display("test calibration done");
        acc(1, 8'h20, 32'h0);
        acc(1, 8'h20, 32'h00000001);
        clear;
        trig(9);
        chk_stream(1, 3, 0, 12'h0);
        clear;
        rd(8'h20, 32'h00000001);
        trig(1);
        wait_bytes(1);
        cmp(ql[0], 1);
        $display("test open_packet done");
        acc(1, 8'h20, 32'h0);
        acc(1, 8'h20, 32'h00030101);
        clear;
        stall = 1'b1;
        trig(11);
        rd(8'h20, 32'h01030101);
        stall = 1'b0;
        wait_bytes(4);
        repeat (60) @(negedge mclk);
        cmp(qb.size(), 12);
        rd(8'h20, 32'h00030101);
        $display("test drop done");
        report_and_stop;
    end
endmodule // test_adc_sample_packetizer
bind adc_sample_packetizer adc_sample_packetizer_asserts chk_u (.mclk(mclk), .rst(rst),
    .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_ack(reg_ack), .conv_start(conv_start), .conv_pin(conv_pin),
    .net_valid(net_valid), .net_ready(net_ready), .net_byte(net_byte), .net_dest(net_dest),
    .net_last(net_last));
